/* design/aps_sequencer.sv */
// aps_sequencer: host-side control of a 10-bit successive-approximation converter.
// assumes strobes are synchronous to mclk; the analog comparator answers within one cycle.
`timescale 1ns/1ps
`default_nettype none
module aps_sequencer #(
    parameter int unsigned WIDTH    = aps_pkg::RES_BITS,
    parameter int unsigned STEP_DIV = aps_pkg::INT_STEP_DIV
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire aps_pkg::aps_bus_t     bus,
    input  wire aps_pkg::aps_afe_t     afe,
    input  wire logic                  use_ext_clk,
    input  wire logic                  external_conversion_clock,
    output logic [WIDTH-1:0]           data_out,
    output logic [WIDTH-1:0]           data_oe_n,
    output logic                       done_n,
    output logic                       sample_mode,
    output logic [WIDTH-1:0]           dac_trial
);
    import aps_pkg::*;

    // theory of operation
    //
    // three states. in tracking the analog switch follows the input and the
    // result latch keeps the last word. a selected write pulse moves to
    // conversion on the edge where the write strobe returns high, not on its
    // falling edge. a host that holds the strobe low for several cycles
    // therefore gets the whole low time as extra sampling time, which eases
    // the settling demand on a high-impedance source.
    //
    // conversion start is registered: start pulses one cycle after the write
    // edge, and the step engine loads its msb trial one cycle after that.
    // the range flags of the front end are captured with the write edge, so
    // a drifting input cannot flip the clamp decision mid-conversion.
    //
    // pacing comes from one of two sources. the internal divider counts mclk
    // and raises step once every STEP_DIV cycles. it runs freely, so the
    // first step after a start may come anywhere from one to STEP_DIV cycles
    // later. the external conversion clock is sampled as a plain input and
    // each rising edge seen in mclk gives one step; it must stay below half
    // of mclk, or edges are lost and the conversion stretches.
    //
    // the step engine resolves one bit per step, msb first, and pulses
    // finished for one cycle after the lsb step. the sequencer then latches
    // either the engine's word or a clamp code and lowers done_n.
    //
    // a write during conversion is ignored: the engine is busy, and a second
    // start would corrupt the partial word. a write while a result waits
    // unread restarts the conversion and discards that result. hosts that
    // care must read before they write again.
    //
    // a selected read takes effect on every edge where it is seen. the bus
    // outputs are registered: data and enables appear one cycle after the
    // read is first seen; the enables return high one cycle after it ends and data_out keeps the word. a read
    // before done returns the previous word and does not stall conversion.
    //
    // done_n is only set from conversion and only cleared from the done
    // state, so set and clear never meet in one cycle.
    //
    // there is no tristate driver here. data_oe_n is one enable per line,
    // low while driving, for the pad ring to use.
    //
    // limits: the divider is eight bits wide, so STEP_DIV above 256 is
    // refused at elaboration. STEP_DIV times one more than the width must
    // fit in the conversion budget held in the package.
    //
    // hazard: the comparator must answer within one cycle of a new trial.
    // the step engine reads cmp_hi on the step edge itself, at the earliest
    // one cycle after the trial changed.
    //
    // reset puts the block in tracking with done_n high, the bus released
    // and a zero result; wr_q resets low, so the first write cannot end before the second edge after release.

    initial begin
        if (WIDTH != RES_BITS) $error("aps_sequencer: WIDTH must match result width");
        if (STEP_DIV > 256) $error("aps_sequencer: STEP_DIV exceeds divider width");
        if (STEP_DIV < 1 || (STEP_DIV * (WIDTH + 1)) > CONV_MAX_CYC)
            $error("aps_sequencer: STEP_DIV too slow for conversion time");
    end

    typedef struct packed {
        // control state and strobe history
        aps_state_t       st;
        logic             wr_q;
        // conversion clock pacing and conversion start pulse
        logic             xclk_q;
        logic [7:0]       div;
        logic             step;
        logic             start;
        // result latch and flag
        logic [WIDTH-1:0] result;
        logic             done_n;
        // bus side
        logic             drive;
        logic [WIDTH-1:0] dout;
        // range flags captured at start
        logic             clamp_hi;
        logic             clamp_lo;
    } aps_seq_t;

    aps_seq_t s_r, s_nxt;

    // a strobe counts only while the device is selected
    function automatic logic selected(input logic cs_n, input logic strobe_n);
        return !cs_n && !strobe_n;
    endfunction

    // common entry into hold, from tracking and from an unread result
    function automatic aps_seq_t enter_hold(input aps_seq_t cur, input aps_afe_t fe);
        aps_seq_t nx;
        nx          = cur;
        nx.st       = APS_CONVERT;
        nx.start    = 1'b1;
        nx.done_n   = 1'b1;
        nx.clamp_hi = fe.over_ref;
        nx.clamp_lo = fe.under_ref;
        return nx;
    endfunction

    logic             wr_q_lo;
    logic             rd_sel;
    logic             wr_rise;
    logic [WIDTH-1:0] trial;
    logic             finished;

    // strobes only count while the device is selected
    assign wr_q_lo = selected(bus.cs_n, bus.wr_n);
    assign rd_sel  = selected(bus.cs_n, bus.rd_n);
    assign wr_rise = s_r.wr_q && !wr_q_lo && !bus.cs_n;

    // next state of the whole sequencer
    always_comb begin
        s_nxt        = s_r;
        s_nxt.wr_q   = wr_q_lo;
        s_nxt.xclk_q = external_conversion_clock;
        s_nxt.start  = 1'b0;
        s_nxt.step   = 1'b0;

        // conversion clock: internal divider or external rising edge
        if (use_ext_clk) begin
            s_nxt.div  = '0;
            s_nxt.step = external_conversion_clock && !s_r.xclk_q;
        end else if (s_r.div >= 8'(STEP_DIV - 1)) begin
            s_nxt.div  = '0;
            s_nxt.step = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 8'h01;
        end

        case (s_r.st)
            APS_SAMPLE: begin
                // tracking; a new write ends sampling
                if (wr_rise) begin
                    s_nxt = enter_hold(s_nxt, afe);
                end
            end
            APS_CONVERT: begin
                // runs by itself, no host action needed
                if (finished) begin
                    if (s_r.clamp_hi) s_nxt.result = CODE_FULL;
                    else if (s_r.clamp_lo) s_nxt.result = CODE_ZERO;
                    else s_nxt.result = trial;
                    s_nxt.done_n = 1'b0;
                    s_nxt.st     = APS_DONE;
                end
            end
            APS_DONE: begin
                // a read returns done high and back to tracking
                if (rd_sel) begin
                    s_nxt.done_n = 1'b1;
                    s_nxt.st     = APS_SAMPLE;
                end else if (wr_rise) begin
                    // unread result overwritten by a fresh conversion
                    s_nxt = enter_hold(s_nxt, afe);
                end
            end
            default: begin
                s_nxt.st = APS_SAMPLE;
            end
        endcase

        // bus driven only during a selected read, released after
        s_nxt.drive = rd_sel;
        if (rd_sel) begin
            // a word latched in this same cycle shows from the next read edge
            s_nxt.dout = s_r.result;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r        <= '0;
            s_r.st     <= APS_SAMPLE;
            s_r.done_n <= 1'b1;
            s_r.result <= RESULT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // step engine, paced every STEP_DIV cycles or by external clock edges
    aps_sar_step #(
        .WIDTH    (WIDTH)
    ) u_step (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .start    (s_r.start),
        .step_en  (s_r.step),
        .cmp_hi   (afe.cmp_hi),
        .trial    (trial),
        .finished (finished)
    );

    // bus and done_n outputs come straight from flip-flops; sample_mode is decoded from st and start
    assign data_out    = s_r.dout;
    assign data_oe_n   = {WIDTH{!s_r.drive}};
    assign done_n      = s_r.done_n;
    assign sample_mode = (s_r.st != APS_CONVERT) && !s_r.start;
    assign dac_trial   = trial;
endmodule
`default_nettype wire

/* design/aps_pkg.sv */
// aps_pkg: constants, types and the state encoding for the converter sequencer.
// assumes a single 100 MHz clock domain; every input is synchronous to mclk.
package aps_pkg;

    localparam int unsigned RES_BITS     = 10;
    localparam int unsigned CLK_MHZ      = 100;
    // worst-case conversion time, microseconds
    localparam int unsigned CONV_TIME_US = 6;
    localparam int unsigned CONV_MAX_CYC = CONV_TIME_US * CLK_MHZ;
    // internal conversion clock divider: one step every this many mclk cycles
    localparam int unsigned INT_STEP_DIV = 24;
    localparam logic [RES_BITS-1:0] CODE_FULL  = 10'h3FF;
    localparam logic [RES_BITS-1:0] CODE_ZERO  = 10'h000;
    localparam logic [RES_BITS-1:0] RESULT_RST = 10'h000;

    typedef enum logic [1:0] {
        APS_SAMPLE,
        APS_CONVERT,
        APS_DONE
    } aps_state_t;

    // host bus strobes, all active low
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } aps_bus_t;

    // analog front end as seen by the logic
    typedef struct packed {
        logic                cmp_hi;    // comparator: input above trial level
        logic                over_ref;  // input above upper reference
        logic                under_ref; // input below lower reference
    } aps_afe_t;

endpackage

/* design/aps_sar_step.sv */
// aps_sar_step: one successive-approximation step engine.
// assumes step_en pulses once per conversion clock period.
`timescale 1ns/1ps
`default_nettype none
module aps_sar_step #(
    parameter int unsigned WIDTH = 10
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             start,
    input  wire logic             step_en,
    input  wire logic             cmp_hi,
    output logic [WIDTH-1:0]      trial,
    output logic                  finished
);
    initial begin
        if (WIDTH < 2 || WIDTH > 16) $error("aps_sar_step: WIDTH out of range");
    end

    typedef struct packed {
        logic [WIDTH-1:0] code;
        logic [WIDTH-1:0] bitp;  // one-hot position under test
        logic             busy;
        logic             fin;
    } aps_sar_t;

    aps_sar_t s_r, s_nxt;

    // one bit resolved per step, msb first
    always_comb begin
        s_nxt     = s_r;
        s_nxt.fin = 1'b0;
        if (start) begin
            s_nxt.bitp = {1'b1, {(WIDTH-1){1'b0}}};
            s_nxt.code = {1'b1, {(WIDTH-1){1'b0}}};
            s_nxt.busy = 1'b1;
        end else if (s_r.busy && step_en) begin
            if (!cmp_hi) s_nxt.code = s_r.code & ~s_r.bitp;
            if (s_r.bitp[0]) begin
                s_nxt.busy = 1'b0;
                s_nxt.fin  = 1'b1;
            end else begin
                s_nxt.bitp = s_r.bitp >> 1;
                s_nxt.code = (!cmp_hi ? (s_r.code & ~s_r.bitp) : s_r.code)
                             | (s_r.bitp >> 1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trial    = s_r.code;
    assign finished = s_r.fin;
endmodule
`default_nettype wire

/* tb/aps_props.sv */
// aps_props: strobe, flag and bus-release timing checks.
// assumes it is bound onto aps_sequencer in one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module aps_props #(
    parameter int unsigned WIDTH = 10
) (
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire aps_pkg::aps_bus_t bus,
    input wire aps_pkg::aps_afe_t afe,
    input wire logic              use_ext_clk,
    input wire logic              external_conversion_clock,
    input wire logic [WIDTH-1:0]  data_out,
    input wire logic [WIDTH-1:0]  data_oe_n,
    input wire logic              done_n,
    input wire logic              sample_mode,
    input wire logic [WIDTH-1:0]  dac_trial
);
    import aps_pkg::*;
    localparam int CONV_CYC = 600;
    logic wr_q;
    logic cs_q;
    logic wr_evt;
    logic rd_sel;
    // last strobe levels, so a write is seen on its rising edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b1;
            cs_q <= 1'b1;
        end else begin
            wr_q <= bus.wr_n;
            cs_q <= bus.cs_n;
        end
    end
    // selected write edge and selected read level
    assign wr_evt = !cs_q && !wr_q && bus.wr_n && !bus.cs_n;
    assign rd_sel = !bus.cs_n && !bus.rd_n;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_write_start:
        assert property (wr_evt && sample_mode |=> !sample_mode) else $error("no start");
    chk_conv_time:
        assert property (wr_evt && sample_mode |-> ##[1:CONV_CYC] !done_n) else $error("slow");
    chk_cs_ignore:
        assert property (bus.cs_n && sample_mode |=> sample_mode) else $error("unselected");
    chk_read_drive:
        assert property (rd_sel |=> data_oe_n == '0) else $error("read not driven");
    chk_read_clear:
        assert property (rd_sel && !done_n |=> done_n) else $error("read left done low");
    chk_bus_release:
        assert property (bus.rd_n || bus.cs_n |=> data_oe_n == '1) else $error("not released");
    chk_done_hold:
        assert property (!done_n && !rd_sel && !wr_evt |=> !done_n) else $error("done lost");
    chk_data_hold:
        assert property (rd_sel && $past(rd_sel) |=> $stable(data_out)) else $error("data moved");
    chk_done_clear:
        assert property ($rose(done_n) |-> $past(bus.cs_n) == 1'b0) else $error("done rose alone");
    cover property ($fell(done_n));
    cover property (rd_sel ##1 done_n);
    cover property (wr_evt && use_ext_clk);
endmodule
bind aps_sequencer aps_props #(.WIDTH(WIDTH)) u_props (.mclk, .reset_n, .bus, .afe,
    .use_ext_clk, .external_conversion_clock, .data_out, .data_oe_n, .done_n, .sample_mode,
    .dac_trial);
`default_nettype wire

/* tb/aps_afe_model.sv */
// aps_afe_model: analog front end, input given in converter steps.
// assumes the trial code settles before each compare.
`timescale 1ns/1ps
`default_nettype none
module aps_afe_model (
    input  wire logic [9:0]       analog_input,
    input  wire logic             ovr,
    input  wire logic             und,
    input  wire logic [9:0]       dac_trial,
    output wire aps_pkg::aps_afe_t afe
);
    import aps_pkg::*;
    // half-step offset keeps the compare free of ties
    assign afe = '{cmp_hi: {analog_input, 1'b1} > {dac_trial, 1'b0}, over_ref: ovr, under_ref: und};
endmodule
`default_nettype wire

/* tb/adc_parallel_host_sequencer_bench.sv */
// adc_parallel_host_sequencer_bench: converts a table of levels, then edge cases.
// assumes aps_afe_model stands for the analog side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module adc_parallel_host_sequencer_bench;
    import aps_pkg::*;
    typedef struct packed {logic [9:0] analog_input; logic ovr; logic und; logic [9:0] exp;} aps_row_t;
    localparam aps_row_t ROWS [6] = '{'{10'h2A5, 0, 0, 10'h2A5}, '{10'h000, 0, 0, 10'h000},
        '{10'h3FF, 0, 0, 10'h3FF}, '{10'h155, 1, 0, 10'h3FF}, '{10'h2AA, 0, 1, 10'h000},
        '{10'h001, 0, 0, 10'h001}};
    logic mclk, reset_n, use_ext_clk, ext_clk, ovr, und, done_n, sample_mode;
    logic [9:0] analog_input, data_out, data_oe_n, dac_trial;
    aps_bus_t bus;
    aps_afe_t afe;
    int num_errors = 0;
    int compares = 0;
    aps_afe_model u_afe (.analog_input(analog_input), .ovr(ovr), .und(und), .dac_trial(dac_trial), .afe(afe));
    aps_sequencer #(.STEP_DIV(2)) DUT (.mclk(mclk), .reset_n(reset_n), .bus(bus), .afe(afe),
        .use_ext_clk(use_ext_clk), .external_conversion_clock(ext_clk), .data_out(data_out),
        .data_oe_n(data_oe_n), .done_n(done_n), .sample_mode(sample_mode),
        .dac_trial(dac_trial));
    // mclk at 100 MHz, step clock unrelated in phase
    always #5 mclk = ~mclk;
    always #31 ext_clk = ~ext_clk;
    task automatic print_verdict();
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // settle, then a selected write; released one cycle after wr_n rises
    task automatic write_pulse();
        repeat (4) @(negedge mclk);
        bus = '{cs_n: 1'b0, wr_n: 1'b0, rd_n: 1'b1};
        @(negedge mclk) bus.wr_n = 1'b1;
        @(negedge mclk) bus.cs_n = 1'b1;
        @(negedge mclk);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done_n !== 1'b0 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        `CHK("done_n", 1'b0, done_n)
    endtask
    task automatic read_check(input logic [9:0] exp);
        bus = '{cs_n: 1'b0, wr_n: 1'b1, rd_n: 1'b0};
        repeat (2) @(negedge mclk);
        `CHK("data_out", exp, data_out)
        `CHK("oe_read", 10'h000, data_oe_n)
        `CHK("done_read", 1'b1, done_n)
        bus = '1;
        @(negedge mclk);
        `CHK("oe_idle", 10'h3FF, data_oe_n)
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #(20000 * 10);
        num_errors++;
        print_verdict();
    end
    initial begin
        {mclk, ext_clk, reset_n, use_ext_clk, analog_input, ovr, und} = '0;
        bus = '1;
        repeat (4) @(negedge mclk);
        `CHK("oe_rst", 10'h3FF, data_oe_n)
        `CHK("done_rst", 1'b1, done_n)
        reset_n = 1'b1;
        foreach (ROWS[i]) begin
            {analog_input, ovr, und} = {ROWS[i].analog_input, ROWS[i].ovr, ROWS[i].und};
            use_ext_clk = i[0];
            write_pulse();
            wait_done();
            read_check(ROWS[i].exp);
        end
        // read in mid-conversion still shows the previous word
        {analog_input, ovr, und} = {10'h0F0, 2'b00};
        write_pulse();
        `CHK("sample_conv", 1'b0, sample_mode)
        `CHK("trial_msb", 10'h200, dac_trial)
        read_check(10'h001);
        wait_done();
        read_check(10'h0F0);
        // strobes with the device unselected are ignored
        bus = '{cs_n: 1'b1, wr_n: 1'b0, rd_n: 1'b0};
        repeat (3) @(negedge mclk);
        bus = '1;
        @(negedge mclk);
        `CHK("sample_mode", 1'b1, sample_mode)
        `CHK("oe_unsel", 10'h3FF, data_oe_n)
        // reset in mid-conversion returns to tracking, then a clean run
        write_pulse();
        reset_n = 1'b0;
        @(negedge mclk);
        `CHK("done_mid_rst", 1'b1, done_n)
        `CHK("sample_mid_rst", 1'b1, sample_mode)
        `CHK("trial_mid_rst", 10'h000, dac_trial)
        reset_n = 1'b1;
        write_pulse();
        wait_done();
        read_check(10'h0F0);
        print_verdict();
    end
endmodule
`default_nettype wire
